// >>> hdl/lpmc_ctrl.sv
/*
 * lpmc_ctrl: low-power mode controller. Takes sleep requests from the core,
 * gates clocks, steers the core-domain regulator and holds chip reset.
 * assumes: core signals are on sys_clk_in; pins and detector are asynchronous.
 */
// Operation
// - run plus sleep, stop, standby, and a wake reset mode
// - sleep halts only the processor core
// - sleep gates only the core clock
// - stop needs deep sleep, select and instruction
// - stop kills domain clocks and fast oscillators
// - stop keeps domain powered, regulator per bit
// - standby switches the core regulator off
// - standby marks core domain contents lost
// - supply fault holds whole chip in reset
// - run: full regulator, no gating
// - standby select picks stop or standby
// - stop regulator bit picks normal or lowpower
// - interrupt (wait for interrupt) or event (wait for event) ends sleep or stop
// - standby ends on pin, alarm, reset, watchdog
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl import lpmc_pkg::*; #(
	parameter int WAKE_RESET_CYCLES = LPMC_WAKE_RESET_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// core sleep request, same clock
	input wire lpmc_req_s req_in,
	// wake sources on the same clock
	input wire logic interrupt_in,
	input wire logic event_in,
	input wire logic alarm_in,
	// asynchronous pins
	input wire logic wakeup_pin_in,
	input wire logic external_reset_pin_n_in,
	input wire logic independent_watchdog_in,
	input wire logic power_down_reset_in,
	// controls
	output lpmc_ctl_s ctl_out,
	output logic chip_resetn_out,
	output logic sleeping_out,
	output logic woke_by_event_out
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		lpmc_mode_e mode;
		logic by_event;
		logic stop_lowpower;
		logic [15:0] count;
		lpmc_ctl_s ctl;
		logic chip_resetn;
		logic woke_event;
	} lpmc_state_s;

	lpmc_state_s state_reg;
	lpmc_state_s state_next;

	logic wakeup_rise;
	logic ext_reset_n;
	logic watchdog;
	logic supply_low;
	logic sleep_cmd;
	logic standby_wake;

	// ****************************************
	// pin conditioning
	// ****************************************
	lpmc_rise u_wakeup (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.pin_in(wakeup_pin_in),
		.rise_out(wakeup_rise)
	);

	lpmc_sync #(.RESET_VALUE(1'b1)) u_ext_reset (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.pin_in(external_reset_pin_n_in),
		.level_out(ext_reset_n)
	);

	lpmc_sync #(.RESET_VALUE(1'b0)) u_watchdog (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.pin_in(independent_watchdog_in),
		.level_out(watchdog)
	);

	// a fault at reset is assumed present until the filter says otherwise
	lpmc_sync #(.RESET_VALUE(1'b1)) u_supply (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.pin_in(power_down_reset_in),
		.level_out(supply_low)
	);

	// ****************************************
	// control decode
	// ****************************************
	function automatic lpmc_ctl_s ctl_for(input lpmc_mode_e mode, input logic lowpower);
		lpmc_ctl_s c;
		c = '{core_clk_en: 1'b1, domain_clk_en: 1'b1, periph_run: 1'b1,
			high_speed_internal_osc_en: 1'b1, high_speed_external_osc_en: 1'b1,
			regulator: LPMC_REG_NORMAL, core_domain_lost: 1'b0};
		case (mode)
			LPMC_SLEEP: begin
				c.core_clk_en = 1'b0;
			end
			LPMC_STOP: begin
				c.core_clk_en = 1'b0;
				c.domain_clk_en = 1'b0;
				c.periph_run = 1'b0;
				c.high_speed_internal_osc_en = 1'b0;
				c.high_speed_external_osc_en = 1'b0;
				c.regulator = (lowpower == LPMC_STOP_REG_LOWPOWER) ?
					LPMC_REG_LOWPOWER : LPMC_REG_NORMAL;
			end
			LPMC_STANDBY: begin
				c.core_clk_en = 1'b0;
				c.domain_clk_en = 1'b0;
				c.periph_run = 1'b0;
				c.high_speed_internal_osc_en = 1'b0;
				c.high_speed_external_osc_en = 1'b0;
				c.regulator = LPMC_REG_OFF;
				c.core_domain_lost = 1'b1;
			end
			LPMC_WAKE_RESET: begin
				c.core_clk_en = 1'b0;
				c.periph_run = 1'b0;
			end
			default: begin
			end
		endcase
		return c;
	endfunction : ctl_for

	assign sleep_cmd = req_in.wait_for_interrupt_instr | req_in.wait_for_event_instr;
	assign standby_wake = wakeup_rise | alarm_in | ~ext_reset_n | watchdog;

	// ****************************************
	// mode sequencing
	// ****************************************
	always_comb begin
		state_next = state_reg;
		state_next.woke_event = 1'b0;
		case (state_reg.mode)
			LPMC_RUN: begin
				if (sleep_cmd) begin
					// request and bits captured here only
					state_next.by_event = ~req_in.wait_for_interrupt_instr;
					state_next.stop_lowpower = req_in.stop_regulator_lowpower;
					if (!req_in.deep_sleep_request) begin
						state_next.mode = LPMC_SLEEP;
					end else if (req_in.standby_select == LPMC_STANDBY_SEL_STOP) begin
						state_next.mode = LPMC_STOP;
					end else begin
						state_next.mode = LPMC_STANDBY;
					end
				end
			end
			LPMC_SLEEP, LPMC_STOP: begin
				// wake source follows the entering instruction
				if (state_reg.by_event ? event_in : interrupt_in) begin
					state_next.mode = LPMC_RUN;
					state_next.woke_event = state_reg.by_event;
				end
			end
			LPMC_STANDBY: begin
				if (standby_wake) begin
					state_next.mode = LPMC_WAKE_RESET;
					state_next.count = 16'(WAKE_RESET_CYCLES);
				end
			end
			LPMC_WAKE_RESET: begin
				if (state_reg.count != 16'h0000) begin
					state_next.count = state_reg.count - 16'h0001;
				end else if (ext_reset_n) begin
					state_next.mode = LPMC_RUN;
				end
			end
			default: begin
				state_next.mode = LPMC_RUN;
			end
		endcase
		if (supply_low) begin
			state_next.mode = LPMC_WAKE_RESET;
			state_next.count = 16'(WAKE_RESET_CYCLES);
		end
		state_next.ctl = ctl_for(state_next.mode, state_next.stop_lowpower);
		state_next.chip_resetn = (state_next.mode != LPMC_WAKE_RESET);
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= '{mode: LPMC_WAKE_RESET, by_event: 1'b0, stop_lowpower: 1'b0,
				count: 16'h0000,
				ctl: '{core_clk_en: 1'b0, domain_clk_en: 1'b1, periph_run: 1'b0,
					high_speed_internal_osc_en: 1'b1, high_speed_external_osc_en: 1'b1,
					regulator: LPMC_REG_NORMAL, core_domain_lost: 1'b0},
				chip_resetn: 1'b0, woke_event: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign ctl_out = state_reg.ctl;
	assign chip_resetn_out = state_reg.chip_resetn;
	assign sleeping_out = (state_reg.mode == LPMC_SLEEP) | (state_reg.mode == LPMC_STOP)
		| (state_reg.mode == LPMC_STANDBY);
	assign woke_by_event_out = state_reg.woke_event;
endmodule : lpmc_ctrl
`default_nettype wire

// >>> hdl/lpmc_pkg.sv
/*
 * lpmc_pkg: shared types and constants of the low-power mode controller.
 * assumes: included before every lpmc design file.
 */
package lpmc_pkg;

	// ****************************************
	// modes and regulator states
	// ****************************************
	typedef enum {LPMC_RUN, LPMC_SLEEP, LPMC_STOP, LPMC_STANDBY, LPMC_WAKE_RESET} lpmc_mode_e;

	typedef enum logic [1:0] {LPMC_REG_NORMAL, LPMC_REG_LOWPOWER, LPMC_REG_OFF} lpmc_reg_e;

	// ****************************************
	// sleep request from the core
	// ****************************************
	typedef struct packed {
		logic wait_for_interrupt_instr;
		logic wait_for_event_instr;
		logic deep_sleep_request;
		logic standby_select;
		logic stop_regulator_lowpower;
	} lpmc_req_s;

	// ****************************************
	// wake sources
	// ****************************************
	typedef struct packed {
		logic interrupt;
		logic event_in;
		logic wakeup_pin;
		logic alarm;
		logic external_reset_pin;
		logic independent_watchdog;
	} lpmc_wake_s;

	// ****************************************
	// power and clock controls
	// ****************************************
	typedef struct packed {
		logic core_clk_en;
		logic domain_clk_en;
		logic periph_run;
		logic high_speed_internal_osc_en;
		logic high_speed_external_osc_en;
		lpmc_reg_e regulator;
		logic core_domain_lost;
	} lpmc_ctl_s;

	localparam logic LPMC_STANDBY_SEL_STOP = 1'b0;
	localparam logic LPMC_STOP_REG_LOWPOWER = 1'b1;
	// length of the restart reset after standby or a supply fault
	localparam int LPMC_WAKE_RESET_CYCLES = 16;
	localparam int LPMC_SYNC_STAGES = 3;

endpackage : lpmc_pkg

// >>> hdl/lpmc_rise.sv
/*
 * lpmc_rise: synchronised rising-edge detector for the wake-up pin.
 * assumes: pin is asynchronous; output is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module lpmc_rise import lpmc_pkg::*; (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// pin and edge
	input wire logic pin_in,
	output logic rise_out
);
	logic level;
	logic last_reg;

	lpmc_sync #(.RESET_VALUE(1'b0)) u_sync (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.pin_in(pin_in),
		.level_out(level)
	);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_reg <= 1'b0;
		end else begin
			last_reg <= level;
		end
	end

	assign rise_out = level & ~last_reg;
endmodule : lpmc_rise
`default_nettype wire

// >>> hdl/lpmc_sync.sv
/*
 * lpmc_sync: three-stage synchroniser with agreement filter for one pin.
 * assumes: the pin is asynchronous to sys_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync import lpmc_pkg::*; #(
	parameter logic RESET_VALUE = 1'b0
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// pin and result
	input wire logic pin_in,
	output logic level_out
);
	typedef struct packed {
		logic [LPMC_SYNC_STAGES-1:0] stage;
		logic level;
	} lpmc_sync_s;

	lpmc_sync_s state_reg;
	lpmc_sync_s state_next;

	always_comb begin
		state_next = state_reg;
		state_next.stage = {state_reg.stage[LPMC_SYNC_STAGES-2:0], pin_in};
		// first stage feeds only the second; level moves when stages two and three agree
		if (state_reg.stage[1] == state_reg.stage[2]) begin
			state_next.level = state_reg.stage[2];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= {{LPMC_SYNC_STAGES{RESET_VALUE}}, RESET_VALUE};
		end else begin
			state_reg <= state_next;
		end
	end

	assign level_out = state_reg.level;
endmodule : lpmc_sync
`default_nettype wire

// >>> verification/lpmc_core_model.sv
/* lpmc_core_model: core side, one-cycle sleep instruction with its bits.
 * assumes: go_in from the bench on sys_clk_in. */
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model import lpmc_pkg::*; (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// bench command, request out
	input wire logic go_in,
	input wire lpmc_req_s cmd_in,
	output lpmc_req_s req_out
);
	// ****
	// request
	// ****
	// after the instruction the config bits flip, so a late sample shows
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) req_out <= '0;
		else if (go_in) req_out <= cmd_in;
		else req_out <= {2'b00, ~cmd_in[2:0]};
	end
endmodule : lpmc_core_model
`default_nettype wire

// >>> verification/lpmc_ctrl_assertions.sv
/* lpmc_ctrl_assertions: port timing checks of lpmc_ctrl.
 * assumes: bound to lpmc_ctrl, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl_assertions import lpmc_pkg::*; (
	// watched inputs
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire lpmc_req_s req_in,
	input wire logic interrupt_in,
	input wire logic event_in,
	input wire logic alarm_in,
	input wire logic power_down_reset_in,
	// watched outputs
	input wire lpmc_ctl_s ctl_out,
	input wire logic chip_resetn_out,
	input wire logic sleeping_out
);
	// ****
	// checks
	// ****
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	logic run, go, wfe_reg;
	assign run = chip_resetn_out && !sleeping_out;
	assign go = run && (req_in.wait_for_interrupt_instr || req_in.wait_for_event_instr);
	// entry kind decides which source wakes
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) wfe_reg <= 1'b0;
		else if (go) wfe_reg <= !req_in.wait_for_interrupt_instr;
	end
	a_sleep_core_only: assert property (go && !req_in.deep_sleep_request |=>
		sleeping_out && ctl_out == 8'h78) else $error("sleep controls");
	a_stop_all_off: assert property (go && req_in.deep_sleep_request && !req_in.standby_select |=>
		ctl_out == {6'h00, $past(req_in.stop_regulator_lowpower), 1'b0}) else $error("stop controls");
	a_standby_power_off: assert property (go && req_in.deep_sleep_request && req_in.standby_select
		|=> ctl_out.regulator == LPMC_REG_OFF && ctl_out.core_domain_lost) else $error("standby");
	a_run_full_power: assert property (run |-> ctl_out == 8'hf8) else $error("run controls");
	a_mode_held: assert property (sleeping_out && ctl_out.regulator != LPMC_REG_OFF
		&& !interrupt_in && !event_in |=> sleeping_out && $stable(ctl_out)) else $error("held");
	a_light_wake: assert property (sleeping_out && ctl_out.regulator != LPMC_REG_OFF
		&& (wfe_reg ? event_in : interrupt_in) |=> run) else $error("wake");
	a_supply_reset: assert property (power_down_reset_in [*6] |-> !chip_resetn_out)
		else $error("supply");
	a_standby_wake: assert property (sleeping_out && ctl_out.regulator == LPMC_REG_OFF
		&& alarm_in |-> ##[1:8] !chip_resetn_out) else $error("standby wake");
endmodule : lpmc_ctrl_assertions
bind lpmc_ctrl lpmc_ctrl_assertions u_chk(.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
	.req_in(req_in), .interrupt_in(interrupt_in), .event_in(event_in), .alarm_in(alarm_in),
	.power_down_reset_in(power_down_reset_in), .ctl_out(ctl_out),
	.chip_resetn_out(chip_resetn_out), .sleeping_out(sleeping_out));
`default_nettype wire

// >>> verification/test_low_power_mode_controller.sv
/* test_low_power_mode_controller: bench for lpmc_ctrl with a core model.
 * assumes: lpmc_pkg, lpmc_core_model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_controller;
	import lpmc_pkg::*;
	// ****
	// bench
	// ****
	logic sys_clk_in, rstn_in, go, intr, evt, alarm, wpin, xrst_n, wdog, power_down_reset, chip, slp, wbe;
	lpmc_req_s cmd, req;
	lpmc_ctl_s ctl;
	int error_cnt, compares, cycles;
	lpmc_core_model core(.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .go_in(go),
		.cmd_in(cmd), .req_out(req));
	// short restart count keeps the run brief
	lpmc_ctrl #(.WAKE_RESET_CYCLES(2)) uut(.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.req_in(req), .interrupt_in(intr), .event_in(evt), .alarm_in(alarm),
		.wakeup_pin_in(wpin), .external_reset_pin_n_in(xrst_n),
		.independent_watchdog_in(wdog), .power_down_reset_in(power_down_reset), .ctl_out(ctl),
		.chip_resetn_out(chip), .sleeping_out(slp), .woke_by_event_out(wbe));
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			final_report;
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		$display("error_cnt %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task wait_rst(input logic v);
		int n;
		n = 0;
		while (chip !== v && n < 60) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		chk(chip, v);
	endtask : wait_rst
	task enter(input lpmc_req_s r);
		@(posedge sys_clk_in);
		go <= 1'b1;
		cmd <= r;
		@(posedge sys_clk_in);
		go <= 1'b0;
		@(posedge sys_clk_in);
		#1;
	endtask : enter
	// wrong source first, then the one that matches the entry
	task t_light(input lpmc_req_s r, input logic [7:0] exp);
		enter(r);
		chk(ctl, exp);
		@(posedge sys_clk_in);
		intr <= !r.wait_for_interrupt_instr;
		evt <= r.wait_for_interrupt_instr;
		@(posedge sys_clk_in);
		intr <= r.wait_for_interrupt_instr;
		evt <= !r.wait_for_interrupt_instr;
		#1;
		chk(slp, 1'b1);
		@(posedge sys_clk_in);
		intr <= 1'b0;
		evt <= 1'b0;
		#1;
		chk(ctl, 8'hf8);
		chk(wbe, !r.wait_for_interrupt_instr);
	endtask : t_light
	task t_standby(input int src);
		enter(5'b10110);
		chk(ctl[2:0], 3'b101);
		@(posedge sys_clk_in);
		case (src)
			0: wpin <= 1'b1;
			1: alarm <= 1'b1;
			2: xrst_n <= 1'b0;
			default: wdog <= 1'b1;
		endcase
		wait_rst(1'b0);
		@(posedge sys_clk_in);
		wpin <= 1'b0;
		alarm <= 1'b0;
		xrst_n <= 1'b1;
		wdog <= 1'b0;
		wait_rst(1'b1);
		chk(ctl, 8'hf8);
	endtask : t_standby
	task t_supply;
		@(posedge sys_clk_in);
		power_down_reset <= 1'b1;
		wait_rst(1'b0);
		repeat (10) @(posedge sys_clk_in);
		#1;
		chk(chip, 1'b0);
		@(posedge sys_clk_in);
		power_down_reset <= 1'b0;
		wait_rst(1'b1);
	endtask : t_supply
	initial begin
		{rstn_in, go, intr, evt, alarm, wpin, wdog, power_down_reset} = '0;
		xrst_n = 1'b1;
		cmd = '0;
		repeat (20) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		wait_rst(1'b1);
		chk(ctl, 8'hf8);
		t_light(5'b10000, 8'h78);
		t_light(5'b01000, 8'h78);
		t_light(5'b11000, 8'h78);
		t_light(5'b10100, 8'h00);
		t_light(5'b01101, 8'h02);
		for (int s = 0; s < 4; s++) t_standby(s);
		t_supply;
		final_report;
	end
endmodule : test_low_power_mode_controller
`default_nettype wire
